// *** shared/cfg_space_pkg.sv ***
/*
  package for the type0 configuration space block: register offsets,
  field layout, preset values and the structs for identifiers, requests and credits.
  assumes a single 250 MHz clock and a plain register port.
*/
package cfg_space_pkg;

  // dword byte addresses of the type0 header
  localparam logic [11:0] off_id_word      = 12'h000;
  localparam logic [11:0] off_cmd_status   = 12'h004;
  localparam logic [11:0] off_class_rev    = 12'h008;
  localparam logic [11:0] off_self_test_info_hdr     = 12'h00c;
  localparam logic [11:0] off_bar_first    = 12'h010;
  localparam logic [11:0] off_bar_last     = 12'h024;
  localparam logic [11:0] off_cardbus      = 12'h028;
  localparam logic [11:0] off_subsys       = 12'h02c;
  localparam logic [11:0] off_option_rom   = 12'h030;
  localparam logic [11:0] off_cap_ptr      = 12'h034;
  // private register: credit advertisement and option readback
  localparam logic [11:0] off_credit_cfg   = 12'h100;
  localparam logic [11:0] off_option_stat  = 12'h104;

  // field positions inside the self_test_info/header dword
  localparam int hdr_lsb  = 16;
  localparam int self_test_info_lsb = 24;

  // preset values (user selectable at generation time)
  localparam logic [15:0] preset_function_type_id      = 16'h0000;
  localparam logic [15:0] preset_maker_id              = 16'h0000;
  localparam logic [23:0] preset_class_code            = 24'h000000;
  localparam logic [7:0]  preset_revision_number       = 8'h00;
  localparam logic [7:0]  preset_self_test_info        = 8'h00;
  localparam logic [7:0]  preset_header_layout         = 8'h00;
  localparam logic [15:0] preset_subsystem_function_id = 16'h0000;
  localparam logic [15:0] preset_subsystem_maker_id    = 16'h0000;
  localparam logic [31:0] preset_cardbus_ptr           = 32'h00000000;
  localparam logic [31:0] preset_option_rom            = 32'h00000000;
  localparam logic        preset_option_rom_en         = 1'b0;
  localparam logic [7:0]  preset_cap_ptr               = 8'h50;

  // six bars: preset value (size mask plus type bits) and enable
  localparam logic [5:0]  preset_bar_en = 6'h03;
  localparam logic [31:0] preset_bar [6] = '{
    32'hfff0000c, 32'hffffffff, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000};

  // non-posted receive credits advertised in init
  localparam logic [5:0]  preset_nph_credits = 6'h20;
  localparam logic [5:0]  preset_npd_credits = 6'h20;
  localparam logic [5:0]  credit_min         = 6'h01;
  localparam logic [5:0]  credit_max         = 6'h20;

  // bar low bits
  localparam int bar_type_lsb = 1;
  localparam logic [1:0] bar_type_64 = 2'h2;

  typedef struct packed {
    logic [15:0] function_type_id;
    logic [15:0] maker_id;
    logic [23:0] class_code;
    logic [7:0]  revision_number;
    logic [15:0] subsystem_function_id;
    logic [15:0] subsystem_maker_id;
  } ident_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] nph;
    logic [5:0] npd;
  } credits_t;

endpackage

// *** verilog/cfg_space.sv ***
/*
  type0 configuration space of an express endpoint with initial
  non-posted credit advertisement and optional identifier loading from
  ports. assumes requests arrive decoded as dword reads and writes on a
  plain register port, one clock mclk, asynchronous active-low rst_n.
*/
// Summary of operation
// RQ1: advertise configurable non-posted header, data credits
// RQ2: header and capability structures load user presets
// RQ3: function type identifier is 16 bit read-only
// RQ4: maker identifier is 16 bit read-only
// RQ5: class code is 24 bit read-only
// RQ6: revision number is 8 bit read-only
// RQ7: self-test field is 8 bit read-only
// RQ8: header layout field is 8 bit read-only
// RQ9: disabled base registers claim no address space
// RQ10: enabled base registers request preset window size
// RQ11: 64-bit windows pair even low, odd high
// RQ12: optional cardbus pointer locates card information
// RQ13: subsystem function identifier 16 bit read-only
// RQ14: subsystem maker identifier 16 bit read-only
// RQ15: option rom enable gates its base field
// RQ16: port loading takes identifiers from user inputs
// RQ17: writes to read-only identity fields ignored
// RQ18: user keeps identifier inputs stable after reset
module cfg_space (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [11:0]               addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  // generation options
  input  wire logic                      identifier_port_loading,
  // user identifier ports, from logic on mclk
  input  wire cfg_space_pkg::ident_t     ident_in,
  // flow control init advertisement
  output cfg_space_pkg::credits_t        init_credits,
  // decoded state for the transaction layer
  output logic      [5:0]                bar_claim,
  output logic                           option_rom_claim,
  output logic                           mem_space_en
);

  typedef struct packed {
    logic [31:0]              rdata;
    cfg_space_pkg::ident_t    ident;
    logic [5:0][31:0]         bar;
    logic [31:0]              option_rom;
    logic [15:0]              command;
    cfg_space_pkg::credits_t  credits;
    logic                     loaded;
    logic [5:0]               claim;
    logic                     rom_claim;
  } state_t;

  state_t cur;
  state_t nxt;

  // a bar is 64-bit when the even one of its pair carries type 10
  function automatic logic is_upper(input logic [5:0][31:0] b, input int i);
    // i & 6 names the even partner and never leaves the array
    return (i % 2 == 1) &&
      (b[i & 6][cfg_space_pkg::bar_type_lsb +: 2] == cfg_space_pkg::bar_type_64);
  endfunction

  // writable bits of a bar are those set in the preset size mask
  function automatic logic [31:0] bar_mask(input int i);
    logic [31:0] m;
    m = cfg_space_pkg::preset_bar[i];
    if (i % 2 == 1 &&
        cfg_space_pkg::preset_bar[i & 6][cfg_space_pkg::bar_type_lsb +: 2] ==
        cfg_space_pkg::bar_type_64) begin
      return m;                                                      // RQ11
    end
    return {m[31:4], 4'h0};                                          // RQ10
  endfunction

  logic [31:0] rd_word;
  logic [2:0]  bar_idx;

  always_comb begin
    bar_idx = 3'((addr - cfg_space_pkg::off_bar_first) >> 2);
    rd_word = 32'h00000000;
    unique case (1'b1)
      addr == cfg_space_pkg::off_id_word:
        rd_word = {cur.ident.function_type_id, cur.ident.maker_id};  // RQ3 RQ4
      addr == cfg_space_pkg::off_cmd_status:
        rd_word = {16'h0010, cur.command};
      addr == cfg_space_pkg::off_class_rev:
        rd_word = {cur.ident.class_code, cur.ident.revision_number}; // RQ5 RQ6
      addr == cfg_space_pkg::off_self_test_info_hdr:
        rd_word = {cfg_space_pkg::preset_self_test_info,
                   cfg_space_pkg::preset_header_layout, 16'h0000};   // RQ7 RQ8
      addr >= cfg_space_pkg::off_bar_first && addr <= cfg_space_pkg::off_bar_last:
        rd_word = cfg_space_pkg::preset_bar_en[bar_idx] ?
                  cur.bar[bar_idx] : 32'h00000000;                   // RQ9
      addr == cfg_space_pkg::off_cardbus:
        rd_word = cfg_space_pkg::preset_cardbus_ptr;                 // RQ12
      addr == cfg_space_pkg::off_subsys:
        rd_word = {cur.ident.subsystem_function_id,
                   cur.ident.subsystem_maker_id};                    // RQ13 RQ14
      addr == cfg_space_pkg::off_option_rom:
        rd_word = cfg_space_pkg::preset_option_rom_en ?
                  cur.option_rom : 32'h00000000;                     // RQ15
      addr == cfg_space_pkg::off_cap_ptr:
        rd_word = {24'h000000, cfg_space_pkg::preset_cap_ptr};       // RQ2
      addr == cfg_space_pkg::off_credit_cfg:
        rd_word = {20'h00000, cur.credits.npd, cur.credits.nph};     // RQ1
      addr == cfg_space_pkg::off_option_stat:
        rd_word = {24'h000000, 1'b0, cur.rom_claim, cur.claim};
      default:
        rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    nxt       = cur;
    nxt.rdata = rd ? rd_word : cur.rdata;
    // identifiers: presets, or the user ports once after reset release,
    // taken a cycle later so an asynchronous reset never loads a port
    if (!cur.loaded) begin
      nxt.loaded = 1'b1;
      if (identifier_port_loading) begin
        nxt.ident = ident_in;                                        // RQ16 RQ18
      end
    end
    if (wr) begin
      unique case (1'b1)
        addr == cfg_space_pkg::off_cmd_status:
          nxt.command = {5'h00, wdata[10], 8'h00, wdata[1:0]};
        addr >= cfg_space_pkg::off_bar_first && addr <= cfg_space_pkg::off_bar_last:
          if (cfg_space_pkg::preset_bar_en[bar_idx]) begin           // RQ9
            nxt.bar[bar_idx] = (wdata & bar_mask(int'(bar_idx))) |
                               (cfg_space_pkg::preset_bar[bar_idx] &
                                ~bar_mask(int'(bar_idx)));           // RQ10
          end
        addr == cfg_space_pkg::off_option_rom:
          if (cfg_space_pkg::preset_option_rom_en) begin             // RQ15
            nxt.option_rom = wdata & {cfg_space_pkg::preset_option_rom[31:11],
                                      11'h001};
          end
        addr == cfg_space_pkg::off_credit_cfg:
          begin
            if (wdata[5:0] >= cfg_space_pkg::credit_min &&
                wdata[5:0] <= cfg_space_pkg::credit_max) begin
              nxt.credits.nph = wdata[5:0];                          // RQ1
            end
            if (wdata[11:6] >= cfg_space_pkg::credit_min &&
                wdata[11:6] <= cfg_space_pkg::credit_max) begin
              nxt.credits.npd = wdata[11:6];                         // RQ1
            end
          end
        // identity, class, self-test and header words have no write path
        default: nxt.command = nxt.command;                          // RQ17
      endcase
    end
    // a window is claimed only when enabled, assigned and memory is on
    for (int i = 0; i < 6; i++) begin
      nxt.claim[i] = cfg_space_pkg::preset_bar_en[i] && cur.command[1] &&
                     !is_upper(cur.bar, i) &&
                     (cur.bar[i][31:4] != 28'h0000000);              // RQ9 RQ11
    end
    nxt.rom_claim = cfg_space_pkg::preset_option_rom_en &&
                    cur.option_rom[0] && cur.command[1];             // RQ15
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.rdata   <= 32'h00000000;
      cur.ident   <= '{function_type_id:      cfg_space_pkg::preset_function_type_id,
                       maker_id:              cfg_space_pkg::preset_maker_id,
                       class_code:            cfg_space_pkg::preset_class_code,
                       revision_number:       cfg_space_pkg::preset_revision_number,
                       subsystem_function_id: cfg_space_pkg::preset_subsystem_function_id,
                       subsystem_maker_id:    cfg_space_pkg::preset_subsystem_maker_id};
      for (int i = 0; i < 6; i++) begin
        cur.bar[i] <= cfg_space_pkg::preset_bar[i];                  // RQ2 RQ10
      end
      cur.option_rom <= cfg_space_pkg::preset_option_rom;
      cur.command    <= 16'h0000;
      cur.credits    <= '{nph: cfg_space_pkg::preset_nph_credits,
                          npd: cfg_space_pkg::preset_npd_credits};   // RQ1
      cur.loaded     <= 1'b0;
      cur.claim      <= 6'h00;
      cur.rom_claim  <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  assign rdata            = cur.rdata;
  assign init_credits     = cur.credits;
  assign bar_claim        = cur.claim;
  assign option_rom_claim = cur.rom_claim;
  assign mem_space_en     = cur.command[1];

endmodule

// *** bench/cfg_space_assertions.sv ***
/*
  port checker for cfg_space, attached by bind.
  assumes the package presets and the single mclk domain.
*/
module cfg_space_assertions (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // register port
  input wire logic [11:0]             addr,
  input wire logic [31:0]             wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [31:0]             rdata,
  // decoded state
  input wire cfg_space_pkg::credits_t init_credits,
  input wire logic [5:0]              bar_claim,
  input wire logic                    option_rom_claim,
  input wire logic                    mem_space_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  credit_range_a: assert property (init_credits.nph inside {[6'h01:6'h20]}
    && init_credits.npd inside {[6'h01:6'h20]}) else $error("credit out of range");
  credit_hold_a: assert property (!(wr && addr == 12'h100) |=> $stable(init_credits))
    else $error("credits moved without write");
  bar_disabled_a: assert property ((bar_claim & ~cfg_space_pkg::preset_bar_en) == 6'h00)
    else $error("disabled bar claims");
  odd_half_a: assert property (!bar_claim[1]) else $error("upper half claimed");
  rom_off_a: assert property (cfg_space_pkg::preset_option_rom_en || !option_rom_claim)
    else $error("rom claimed while absent");
  mem_follow_a: assert property (wr && addr == 12'h004 |=> mem_space_en == $past(wdata[1]))
    else $error("memory enable not taken");
  hdr_read_a: assert property (rd && addr == 12'h00c |=> rdata[31:16] ==
    {cfg_space_pkg::preset_self_test_info, cfg_space_pkg::preset_header_layout})
    else $error("self test or header wrong");
  cap_read_a: assert property (rd && addr == 12'h034 |=>
    rdata[7:0] == cfg_space_pkg::preset_cap_ptr) else $error("cap pointer wrong");
  rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
  cover property (wr && addr == 12'h010);
  cover property (bar_claim[0]);
  cover property (rd && addr == 12'h100);
  cover property (rd && addr == 12'h034);
endmodule

bind cfg_space cfg_space_assertions cfg_space_assertions_inst (.mclk(mclk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .init_credits(init_credits),
  .bar_claim(bar_claim), .option_rom_claim(option_rom_claim), .mem_space_en(mem_space_en));

// *** bench/cfg_host.sv ***
/*
  host model issuing configuration reads and writes on the register port.
  assumes read data stand in the cycle after the read strobe.
*/
module cfg_host (
  // clock
  input wire logic         mclk,
  // register port
  output logic      [11:0] addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input wire logic  [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 12'h000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // idle address and data are inverted so a stale value never looks valid
  task wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask
  task rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    // data stand from this cycle until the next read; take them at the edge that ends it
    @(posedge mclk);
    v = rdata;
  endtask
endmodule

// *** bench/pcie_type0_config_space_test.sv ***
/*
  self-checking bench for cfg_space with a host model on its register port.
  assumes package presets and the hand-over timing of the register port.
*/
module pcie_type0_config_space_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, ipl, wr, rd, rom_claim, mem_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, d, b;
  logic [5:0] claim, n1, n2;
  cfg_space_pkg::ident_t ident;
  cfg_space_pkg::credits_t cred;
  int n_mismatch, n_tests, i;
  logic [11:0] ro_a [3] = '{12'h000, 12'h008, 12'h02c};

  cfg_host cfg_host_inst (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  cfg_space cfg_space_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .identifier_port_loading(ipl), .ident_in(ident),
    .init_credits(cred), .bar_claim(claim), .option_rom_claim(rom_claim),
    .mem_space_en(mem_en));

  // model of the identity words, from presets or from the user ports
  function automatic logic [31:0] id_exp(int k);
    cfg_space_pkg::ident_t s;
    s = ipl ? ident : {cfg_space_pkg::preset_function_type_id, cfg_space_pkg::preset_maker_id,
      cfg_space_pkg::preset_class_code, cfg_space_pkg::preset_revision_number,
      cfg_space_pkg::preset_subsystem_function_id, cfg_space_pkg::preset_subsystem_maker_id};
    if (k == 0) return {s.function_type_id, s.maker_id};
    if (k == 1) return {s.class_code, s.revision_number};
    return {s.subsystem_function_id, s.subsystem_maker_id};
  endfunction
  task check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rdc(string nm, logic [11:0] a, logic [31:0] exp);
    cfg_host_inst.rd_reg(a, d);
    check(nm, d, exp);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000;
    n_mismatch++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    ipl = 1'b0;
    ident = '0;
    void'($urandom(90454));
    do_reset;
    check("cred", {20'h0, cred}, {20'h0, cfg_space_pkg::preset_nph_credits, cfg_space_pkg::preset_npd_credits});
    for (i = 0; i < 3; i++) begin
      rdc("ident", ro_a[i], id_exp(i));
      cfg_host_inst.wr_reg(ro_a[i], $urandom);
      rdc("ident kept", ro_a[i], id_exp(i));
    end
    b = {cfg_space_pkg::preset_self_test_info, cfg_space_pkg::preset_header_layout, 16'h0000};
    rdc("self test hdr", 12'h00c, b);
    cfg_host_inst.wr_reg(12'h00c, $urandom);
    rdc("self test hdr kept", 12'h00c, b);
    rdc("cap ptr", 12'h034, {24'h000000, cfg_space_pkg::preset_cap_ptr});
    rdc("cardbus", 12'h028, cfg_space_pkg::preset_cardbus_ptr);
    rdc("unmapped", 12'h200, 32'h00000000);
    $display("identity test done");
    cfg_host_inst.wr_reg(12'h004, 32'hffffffff);
    rdc("command", 12'h004, 32'h00100403);
    check("mem on", {31'h0, mem_en}, 32'h1);
    for (i = 0; i < 6; i++) begin
      cfg_host_inst.wr_reg(12'h010 + 12'(4 * i), 32'hffffffff);
      rdc("bar size", 12'h010 + 12'(4 * i), i < 2 ? cfg_space_pkg::preset_bar[i] : 32'h0);
    end
    b = $urandom;
    cfg_host_inst.wr_reg(12'h014, b);
    rdc("bar high half", 12'h014, b);
    check("claim", {26'h0, claim}, 32'h1);
    b = $urandom & 32'hfff00000;
    cfg_host_inst.wr_reg(12'h010, b);
    rdc("bar base", 12'h010, b | 32'hc);
    check("claim base", {26'h0, claim}, {31'h0, b != 0});
    cfg_host_inst.wr_reg(12'h030, 32'hffffffff);
    rdc("rom", 12'h030, 32'h0);
    check("rom claim", {31'h0, rom_claim}, 32'h0);
    cfg_host_inst.wr_reg(12'h004, 32'h0);
    rdc("claim off", 12'h104, 32'h0);
    check("mem off", {31'h0, mem_en}, 32'h0);
    $display("bar test done");
    n1 = 6'($urandom_range(1, 32));
    n2 = 6'($urandom_range(1, 32));
    cfg_host_inst.wr_reg(12'h100, {20'h0, n2, n1});
    rdc("credits", 12'h100, {20'h0, n2, n1});
    cfg_host_inst.wr_reg(12'h100, 32'h0);
    rdc("credits kept", 12'h100, {20'h0, n2, n1});
    check("advertised", {20'h0, cred}, {20'h0, n1, n2});
    $display("credit test done");
    @(posedge mclk);
    ipl <= 1'b1;
    ident <= {$urandom, $urandom, $urandom};
    do_reset;
    for (i = 0; i < 3; i++) rdc("port ident", ro_a[i], id_exp(i));
    $display("port loading test done");
    test_done;
  end
endmodule
